// ### core/bldec_core.sv
/*
  decode and sequencing of the byte load group: fetches opcode and operand
  bytes, counts T states, moves data between registers, memory and the
  vector page / refresh registers, and keeps the flags.
  assumes memory answers a read with mem_rdata valid in the same cycle
  in which mem_req.rd stands and accepts a write in the cycle it is presented.
*/
`timescale 1ns/100ps
`default_nettype none
// How it works
// - register field codes, 110 means memory
// - 01rrr110 reads pair-addressed memory, 7 T
// - index prefix read at index+displacement, 19 T
// - 01110rrr writes register to pair address
// - index prefix write at index+displacement, 19 T
// - 00110110 stores immediate at pair address
// - index prefix immediate store, four bytes, 19T
// - accumulator load via b_c or d_e pair
// - accumulator load from absolute address, 13 T
// - accumulator store via b_c or d_e pair
// - accumulator store to absolute address, 13 T
// - accumulator loads from special registers copy enable flop, clear H, N
// - all other loads keep flags unchanged
// - duration counted in clock periods, fetch included
module bldec_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] mem_rdata,
  input wire logic interrupt_enable_flipflop,
  output bldec_pkg::bldec_mem_t mem_req,
  output logic [15:0] fetch_addr,
  output logic [7:0] flags,
  output logic [7:0] vector_page,
  output logic [7:0] refresh_count,
  output logic [15:0] first_index_register,
  output logic [15:0] second_index_register,
  output logic instr_done,
  output logic [2:0] mcycles_done,
  output logic [63:0] regs
);
  // sequencer states
  typedef enum logic [2:0] {
    BLDEC_S_FETCH = 3'b000,
    BLDEC_S_WAIT = 3'b001,
    BLDEC_S_OPER = 3'b010,
    BLDEC_S_MEM = 3'b011,
    BLDEC_S_PAD = 3'b100
  } bldec_state_t;

  bldec_state_t state;
  logic [1:0] prefix; // 0 none, 1 first index, 2 second index, 3 extended
  bldec_pkg::bldec_op_t op; // latched decode
  bldec_pkg::bldec_op_t dec; // combinational decode
  logic [4:0] tcount; // T states elapsed in this instruction
  logic [7:0] disp; // displacement byte
  logic [7:0] imm; // immediate byte
  logic [15:0] abs_addr; // absolute address being assembled
  logic [1:0] oper_idx; // operand byte index
  logic [7:0] opcode; // last opcode byte
  logic [7:0] rf_rdata;
  logic rf_we;
  logic [2:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic [2:0] rf_raddr;
  logic [7:0] acc;
  logic [15:0] bc_pair, de_pair, high_low_address_pair, idx_base, mem_addr;
  logic is_prefix, last_tick;
  logic [7:0] b_flags;

  // register field codes pick byte lanes of the file
  assign acc = regs[bldec_pkg::REG_A*8 +: 8];
  assign bc_pair = {regs[bldec_pkg::REG_B*8 +: 8], regs[bldec_pkg::REG_C*8 +: 8]};
  assign de_pair = {regs[bldec_pkg::REG_D*8 +: 8], regs[bldec_pkg::REG_E*8 +: 8]};
  assign high_low_address_pair = {regs[bldec_pkg::REG_H*8 +: 8], regs[bldec_pkg::REG_L*8 +: 8]};
  assign idx_base = (prefix == 2'd2) ? second_index_register : first_index_register;
  assign is_prefix = (mem_rdata == bldec_pkg::PFX_FIRST_INDEX) ||
                     (mem_rdata == bldec_pkg::PFX_SECOND_INDEX) ||
                     (mem_rdata == bldec_pkg::PFX_EXTENDED);

  // opcode decode from the byte on the bus
  always_comb begin
    dec = '0;
    dec.dst = mem_rdata[5:3];
    dec.src = mem_rdata[2:0];
    dec.adr = bldec_pkg::BLDEC_ADR_HL;
    if (prefix == 2'd3) begin
      dec.tstates = bldec_pkg::T_EXT;
      dec.mcycles = bldec_pkg::M_TWO;
      dec.spc_rfsh = mem_rdata[3];
      if (mem_rdata == bldec_pkg::OP_A_FROM_VEC || mem_rdata == bldec_pkg::OP_A_FROM_RFSH) begin
        dec.kind = bldec_pkg::BLDEC_K_A_FROM_SPC;
      end else if (mem_rdata == bldec_pkg::OP_VEC_FROM_A ||
                   mem_rdata == bldec_pkg::OP_RFSH_FROM_A) begin
        dec.kind = bldec_pkg::BLDEC_K_SPC_FROM_A;
      end
    end else if (mem_rdata[7:6] == 2'b01 && mem_rdata[5:3] != bldec_pkg::REG_MEM &&
                 mem_rdata[2:0] != bldec_pkg::REG_MEM) begin
      dec.kind = (prefix == 2'd0) ? bldec_pkg::BLDEC_K_REG : bldec_pkg::BLDEC_K_NONE;
      dec.tstates = bldec_pkg::T_REG;
      dec.mcycles = bldec_pkg::M_ONE;
    end else if (mem_rdata[7:6] == 2'b01 && (mem_rdata[5:3] == bldec_pkg::REG_MEM) !=
                 (mem_rdata[2:0] == bldec_pkg::REG_MEM)) begin
      // memory read (rrr110) or write (110rrr)
      dec.kind = (mem_rdata[2:0] == bldec_pkg::REG_MEM) ? bldec_pkg::BLDEC_K_MEM_RD
                                                         : bldec_pkg::BLDEC_K_MEM_WR;
      dec.tstates = bldec_pkg::T_SHORT_MEM;
      dec.mcycles = bldec_pkg::M_TWO;
      if (prefix != 2'd0) begin
        dec.adr = bldec_pkg::BLDEC_ADR_IDX;
        dec.tstates = bldec_pkg::T_INDEXED;
        dec.mcycles = bldec_pkg::M_FIVE;
        dec.operands = 3'd1;
      end
    end else if (mem_rdata == bldec_pkg::OP_MEM_IMM) begin
      dec.kind = bldec_pkg::BLDEC_K_MEM_IMM;
      dec.tstates = bldec_pkg::T_MEM_IMM;
      dec.mcycles = bldec_pkg::M_THREE;
      dec.operands = 3'd1;
      if (prefix != 2'd0) begin
        dec.adr = bldec_pkg::BLDEC_ADR_IDX;
        dec.tstates = bldec_pkg::T_INDEXED;
        dec.mcycles = bldec_pkg::M_FIVE;
        dec.operands = 3'd2;
      end
    end else if (prefix == 2'd0 && mem_rdata[7:6] == 2'b00 &&
                 mem_rdata[2:0] == bldec_pkg::REG_MEM) begin
      dec.kind = bldec_pkg::BLDEC_K_IMM;
      dec.tstates = bldec_pkg::T_SHORT_MEM;
      dec.mcycles = bldec_pkg::M_TWO;
      dec.operands = 3'd1;
    end else if (prefix == 2'd0) begin
      dec.tstates = bldec_pkg::T_SHORT_MEM;
      dec.mcycles = bldec_pkg::M_TWO;
      dec.dst = bldec_pkg::REG_A;
      dec.src = bldec_pkg::REG_A;
      case (mem_rdata)
        bldec_pkg::OP_A_FROM_BC: begin
          dec.kind = bldec_pkg::BLDEC_K_MEM_RD;
          dec.adr = bldec_pkg::BLDEC_ADR_BC;
        end
        bldec_pkg::OP_A_FROM_DE: begin
          dec.kind = bldec_pkg::BLDEC_K_MEM_RD;
          dec.adr = bldec_pkg::BLDEC_ADR_DE;
        end
        bldec_pkg::OP_A_TO_BC: begin
          dec.kind = bldec_pkg::BLDEC_K_MEM_WR;
          dec.adr = bldec_pkg::BLDEC_ADR_BC;
        end
        bldec_pkg::OP_A_TO_DE: begin
          dec.kind = bldec_pkg::BLDEC_K_MEM_WR;
          dec.adr = bldec_pkg::BLDEC_ADR_DE;
        end
        bldec_pkg::OP_A_FROM_ABS, bldec_pkg::OP_A_TO_ABS: begin
          dec.kind = mem_rdata[3] ? bldec_pkg::BLDEC_K_MEM_RD
                                  : bldec_pkg::BLDEC_K_MEM_WR;
          dec.adr = bldec_pkg::BLDEC_ADR_ABS;
          dec.tstates = bldec_pkg::T_ABS;
          dec.mcycles = bldec_pkg::M_FOUR;
          dec.operands = 3'd2;
        end
        default: begin
          dec.kind = bldec_pkg::BLDEC_K_NONE;
          dec.tstates = bldec_pkg::T_REG;
          dec.mcycles = bldec_pkg::M_ONE;
        end
      endcase
    end else begin
      dec.kind = bldec_pkg::BLDEC_K_NONE;
      dec.tstates = bldec_pkg::T_REG;
      dec.mcycles = bldec_pkg::M_ONE;
    end
  end

  // memory operand address by source
  assign mem_addr = (op.adr == bldec_pkg::BLDEC_ADR_IDX) ? 16'(idx_base + {{8{disp[7]}}, disp}) :
                    (op.adr == bldec_pkg::BLDEC_ADR_BC) ? bc_pair :
                    (op.adr == bldec_pkg::BLDEC_ADR_DE) ? de_pair :
                    (op.adr == bldec_pkg::BLDEC_ADR_ABS) ? abs_addr : high_low_address_pair;
  // instruction ends when the T count reaches its total
  assign last_tick = (state == BLDEC_S_PAD) && (tcount + 5'd1 >= op.tstates);
  // source register is looked up while the opcode is decoded, so the
  // registered read data already stand when a pair-addressed write follows
  assign rf_raddr = (state == BLDEC_S_WAIT) ? dec.src : op.src;

  // register file writes: moves, immediates, memory reads, special loads
  always_comb begin
    rf_we = 1'b0;
    rf_waddr = op.dst;
    rf_wdata = rf_rdata;
    if (last_tick) begin
      case (op.kind)
        bldec_pkg::BLDEC_K_REG: rf_we = 1'b1;
        bldec_pkg::BLDEC_K_IMM, bldec_pkg::BLDEC_K_MEM_RD: begin
          rf_we = 1'b1;
          rf_wdata = imm;
        end
        bldec_pkg::BLDEC_K_A_FROM_SPC: begin
          rf_we = 1'b1;
          rf_waddr = bldec_pkg::REG_A;
          rf_wdata = op.spc_rfsh ? refresh_count : vector_page;
        end
        default: rf_we = 1'b0;
      endcase
    end
  end

  // special-load flags: S and Z from data, P/V from enable flop
  always_comb begin
    b_flags = flags; // other loads keep flags
    if (last_tick && op.kind == bldec_pkg::BLDEC_K_A_FROM_SPC) begin
      b_flags[bldec_pkg::FLAG_S] = rf_wdata[7];
      b_flags[bldec_pkg::FLAG_Z] = (rf_wdata == bldec_pkg::RESET_BYTE);
      b_flags[bldec_pkg::FLAG_PV] = interrupt_enable_flipflop;
      b_flags[bldec_pkg::FLAG_H] = 1'b0;
      b_flags[bldec_pkg::FLAG_N] = 1'b0;
    end
  end

  bldec_regfile u_regfile (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr(rf_raddr),
    .rdata(rf_rdata),
    .all_regs(regs)
  );

  // sequencer: fetch, operand bytes, memory access, pad to T total
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BLDEC_S_FETCH;
      prefix <= 2'd0;
      op <= '0;
      tcount <= 5'd0;
      disp <= bldec_pkg::RESET_BYTE;
      imm <= bldec_pkg::RESET_BYTE;
      abs_addr <= bldec_pkg::RESET_WORD;
      oper_idx <= 2'd0;
      opcode <= bldec_pkg::RESET_BYTE;
      fetch_addr <= bldec_pkg::RESET_WORD;
      mem_req <= '0;
      flags <= bldec_pkg::RESET_BYTE;
      vector_page <= bldec_pkg::RESET_BYTE;
      refresh_count <= bldec_pkg::RESET_BYTE;
      first_index_register <= bldec_pkg::RESET_WORD;
      second_index_register <= bldec_pkg::RESET_WORD;
      instr_done <= 1'b0;
      mcycles_done <= 3'd0;
    end else begin
      mem_req <= '0;
      instr_done <= 1'b0;
      flags <= b_flags;
      tcount <= tcount + 5'd1; // one T state per clock period
      case (state)
        BLDEC_S_FETCH: begin
          mem_req.rd <= 1'b1;
          mem_req.addr <= fetch_addr;
          fetch_addr <= 16'(fetch_addr + 16'd1);
          state <= BLDEC_S_WAIT;
        end
        BLDEC_S_WAIT: begin
          opcode <= mem_rdata;
          if (is_prefix && prefix == 2'd0) begin
            prefix <= (mem_rdata == bldec_pkg::PFX_FIRST_INDEX) ? 2'd1 :
                      (mem_rdata == bldec_pkg::PFX_SECOND_INDEX) ? 2'd2 : 2'd3;
            state <= BLDEC_S_FETCH;
          end else begin
            op <= dec;
            oper_idx <= 2'd0;
            state <= (dec.operands != 3'd0) ? BLDEC_S_FETCH : BLDEC_S_PAD;
            if (dec.operands != 3'd0) begin
              state <= BLDEC_S_OPER;
              mem_req.rd <= 1'b1;
              mem_req.addr <= fetch_addr;
              fetch_addr <= 16'(fetch_addr + 16'd1);
            end else if (dec.kind == bldec_pkg::BLDEC_K_MEM_RD ||
                         dec.kind == bldec_pkg::BLDEC_K_MEM_WR) begin
              state <= BLDEC_S_MEM;
            end
          end
        end
        BLDEC_S_OPER: begin
          // operand byte on the bus: displacement first, then immediate
          oper_idx <= oper_idx + 2'd1;
          if (op.adr == bldec_pkg::BLDEC_ADR_ABS) begin
            if (oper_idx == 2'd0) abs_addr[7:0] <= mem_rdata;
            else abs_addr[15:8] <= mem_rdata;
          end else if (op.adr == bldec_pkg::BLDEC_ADR_IDX && oper_idx == 2'd0) begin
            disp <= mem_rdata;
          end else begin
            imm <= mem_rdata;
          end
          if (3'(oper_idx) + 3'd1 < op.operands) begin
            mem_req.rd <= 1'b1;
            mem_req.addr <= fetch_addr;
            fetch_addr <= 16'(fetch_addr + 16'd1);
          end else begin
            state <= (op.kind == bldec_pkg::BLDEC_K_IMM) ? BLDEC_S_PAD : BLDEC_S_MEM;
          end
        end
        BLDEC_S_MEM: begin
          mem_req.addr <= mem_addr;
          mem_req.rd <= (op.kind == bldec_pkg::BLDEC_K_MEM_RD);
          mem_req.wr <= (op.kind != bldec_pkg::BLDEC_K_MEM_RD);
          mem_req.wdata <= (op.kind == bldec_pkg::BLDEC_K_MEM_IMM) ? imm : rf_rdata;
          state <= BLDEC_S_PAD;
        end
        BLDEC_S_PAD: begin
          if (op.kind == bldec_pkg::BLDEC_K_MEM_RD && mem_req.rd) imm <= mem_rdata;
          if (last_tick) begin
            if (op.kind == bldec_pkg::BLDEC_K_SPC_FROM_A) begin
              if (op.spc_rfsh) refresh_count <= acc;
              else vector_page <= acc;
            end
            instr_done <= 1'b1;
            mcycles_done <= op.mcycles;
            prefix <= 2'd0;
            tcount <= 5'd0;
            state <= BLDEC_S_FETCH;
          end
        end
        default: state <= BLDEC_S_FETCH;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### common/bldec_pkg.sv
/*
  package for the byte load group decoder: opcode patterns, register codes,
  machine-cycle and clock-period counts, decoded-operation carrier.
  assumes one clock period per T state at the core clock.
*/
package bldec_pkg;
  // register field codes
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  // prefix bytes
  localparam logic [7:0] PFX_FIRST_INDEX = 8'hDD;
  localparam logic [7:0] PFX_SECOND_INDEX = 8'hFD;
  localparam logic [7:0] PFX_EXTENDED = 8'hED;
  // fixed opcodes
  localparam logic [7:0] OP_MEM_IMM = 8'h36;
  localparam logic [7:0] OP_A_FROM_BC = 8'h0A;
  localparam logic [7:0] OP_A_FROM_DE = 8'h1A;
  localparam logic [7:0] OP_A_FROM_ABS = 8'h3A;
  localparam logic [7:0] OP_A_TO_BC = 8'h02;
  localparam logic [7:0] OP_A_TO_DE = 8'h12;
  localparam logic [7:0] OP_A_TO_ABS = 8'h32;
  localparam logic [7:0] OP_A_FROM_VEC = 8'h57;
  localparam logic [7:0] OP_A_FROM_RFSH = 8'h5F;
  localparam logic [7:0] OP_VEC_FROM_A = 8'h47;
  localparam logic [7:0] OP_RFSH_FROM_A = 8'h4F;
  // flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 1;
  localparam int FLAG_PV = 2;
  localparam int FLAG_H = 4;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 7;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // durations in T states (one clock period each)
  localparam logic [4:0] T_REG = 5'd4;
  localparam logic [4:0] T_SHORT_MEM = 5'd7;
  localparam logic [4:0] T_EXT = 5'd9;
  localparam logic [4:0] T_MEM_IMM = 5'd10;
  localparam logic [4:0] T_ABS = 5'd13;
  localparam logic [4:0] T_INDEXED = 5'd19;
  // machine-cycle counts
  localparam logic [2:0] M_ONE = 3'd1;
  localparam logic [2:0] M_TWO = 3'd2;
  localparam logic [2:0] M_THREE = 3'd3;
  localparam logic [2:0] M_FOUR = 3'd4;
  localparam logic [2:0] M_FIVE = 3'd5;

  // address source for the memory operand
  typedef enum logic [2:0] {
    BLDEC_ADR_HL = 3'b000,
    BLDEC_ADR_IDX = 3'b001,
    BLDEC_ADR_BC = 3'b010,
    BLDEC_ADR_DE = 3'b011,
    BLDEC_ADR_ABS = 3'b100
  } bldec_adr_t;

  // operation kind
  typedef enum logic [3:0] {
    BLDEC_K_NONE = 4'b0000,
    BLDEC_K_REG = 4'b0001,
    BLDEC_K_IMM = 4'b0010,
    BLDEC_K_MEM_RD = 4'b0011,
    BLDEC_K_MEM_WR = 4'b0100,
    BLDEC_K_MEM_IMM = 4'b0101,
    BLDEC_K_A_FROM_SPC = 4'b0110,
    BLDEC_K_SPC_FROM_A = 4'b0111
  } bldec_kind_t;

  // decoded opcode carrier
  typedef struct packed {
    bldec_kind_t kind;
    bldec_adr_t adr;
    logic [2:0] dst;
    logic [2:0] src;
    logic spc_rfsh; // special register is refresh counter, else vector page
    logic [4:0] tstates;
    logic [2:0] mcycles;
    logic [2:0] operands; // bytes still to fetch after the opcode
  } bldec_op_t;

  // memory request carrier
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bldec_mem_t;
endpackage

// ### core/bldec_regfile.sv
/*
  small register file of the seven byte registers, selected by the three-bit
  register field; read data come from a register one cycle after the address.
  ignores writes with code 110 (memory operand), so that entry stays at its reset value.
*/
`timescale 1ns/100ps
`default_nettype none
module bldec_regfile (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] raddr,
  output logic [7:0] rdata,
  output logic [63:0] all_regs
);
  logic [7:0] mem [8]; // index 6 unused storage

  // one write port, per-entry flops
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_entry
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mem[gi] <= bldec_pkg::RESET_BYTE;
        end else if (we && waddr == 3'(gi) && waddr != bldec_pkg::REG_MEM) begin
          mem[gi] <= wdata;
        end
      end
      assign all_regs[gi*8 +: 8] = mem[gi];
    end
  endgenerate

  // registered read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= bldec_pkg::RESET_BYTE;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ### test/bldec_core_assertions.sv
/*
  checker for the byte load group core: pulse shapes, instruction
  durations by machine-cycle count, and flag stability.
  assumes it is bound to bldec_core, its ports joined by name.
*/
`timescale 1ns/100ps
`default_nettype none
module bldec_core_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire bldec_pkg::bldec_mem_t mem_req,
  input wire logic [7:0] flags,
  input wire logic instr_done,
  input wire logic [2:0] mcycles_done
);
  logic [5:0] gap; // clock periods since the last instruction end
  logic seen; // an instruction has ended since reset

  // gap restarts at each instruction end and saturates
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 6'h00;
      seen <= 1'b0;
    end else begin
      gap <= instr_done ? 6'h01 : ((gap == 6'h3f) ? gap : gap + 6'h01);
      seen <= seen | instr_done;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_DONE_PULSE: assert property (instr_done |=> !instr_done [*3])
    else $error("instruction ends closer than four periods");
  AST_M_RANGE: assert property (instr_done |-> mcycles_done inside {[1:5]})
    else $error("machine-cycle count out of range");
  AST_T_ONE: assert property (instr_done && seen && mcycles_done == 3'h1 |-> gap == 6'h04)
    else $error("one-cycle load not four periods");
  AST_T_TWO: assert property (instr_done && seen && mcycles_done == 3'h2 |-> gap inside {6'h07, 6'h09})
    else $error("two-cycle load not seven or nine periods");
  AST_T_THREE: assert property (instr_done && seen && mcycles_done == 3'h3 |-> gap == 6'h0a)
    else $error("three-cycle load not ten periods");
  AST_T_FOUR: assert property (instr_done && seen && mcycles_done == 3'h4 |-> gap == 6'h0d)
    else $error("four-cycle load not thirteen periods");
  AST_T_FIVE: assert property (instr_done && seen && mcycles_done == 3'h5 |-> gap == 6'h13)
    else $error("five-cycle load not nineteen periods");
  AST_PROGRESS: assert property (gap < 6'h16)
    else $error("no instruction end for too long");
  AST_FLAGS_AT_END: assert property ($changed(flags) |-> (instr_done || $past(instr_done)) && mcycles_done == 3'h2)
    else $error("flags changed outside a special accumulator load");
  AST_CARRY_KEEP: assert property ($stable(flags[bldec_pkg::FLAG_C]))
    else $error("carry flag changed");
  AST_WR_PULSE: assert property (mem_req.wr |=> !mem_req.wr)
    else $error("memory write longer than one cycle");
endmodule
bind bldec_core bldec_core_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(mem_req),
  .flags(flags), .instr_done(instr_done), .mcycles_done(mcycles_done));
`default_nettype wire

// ### test/bldec_mem_model.sv
/*
  far-side memory: 64k bytes, read data stand while the registered read
  request stands, which is the cycle in which the core samples them.
  assumes the bench fills the cells before reset is released.
*/
`timescale 1ns/100ps
`default_nettype none
module bldec_mem_model (
  input wire logic ref_clk,
  input wire bldec_pkg::bldec_mem_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] cells [65536]; // memory contents
  logic [7:0] idle; // toggling filler between reads
  initial idle = 8'h00;
  // read data while the request stands, else a toggling pattern
  assign mem_rdata = (mem_req.rd === 1'b1) ? cells[mem_req.addr] : idle;
  always @(posedge ref_clk) begin
    idle <= ~idle;
    if (mem_req.wr === 1'b1) begin
      cells[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule
`default_nettype wire

// ### test/tb_byte_load_group_decoder.sv
/*
  testbench: a random straight-line load program, predicted instruction by
  instruction, compared with registers, flags, writes and durations.
  assumes index registers stay zero and memory below 4k holds code only.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_byte_load_group_decoder;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic iff_in = 1'b0; // interrupt enable level
  logic [7:0] mem_rdata;
  bldec_pkg::bldec_mem_t mem_req;
  logic [7:0] flags, vector_page, refresh_count;
  logic instr_done;
  logic [2:0] mcycles_done;
  logic [63:0] regs;
  int fail_count = 0;
  int total_checks = 0;
  int k = 0; // instructions retired
  int gap = 0; // periods since last end
  int pc = 0; // program counter of the generator
  logic [31:0] seed = 32'hbf29_fd2a;
  logic [7:0] r [8]; // model registers
  logic [7:0] md [65536]; // model memory
  logic [7:0] fl = 8'h00, vec = 8'h00, rf = 8'h00;
  logic cur_iff, next_iff = 1'b0;
  int qt[$], qm[$];
  logic [63:0] qr[$];
  logic [7:0] qf[$], qv[$], qrf[$];
  logic qi[$];
  logic [23:0] qw[$]; // expected writes, address and data

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) iff_in <= next_iff;

  bldec_core DUT (.ref_clk(ref_clk), .rst_n(rst_n), .mem_rdata(mem_rdata),
    .interrupt_enable_flipflop(iff_in), .mem_req(mem_req), .fetch_addr(), .flags(flags),
    .vector_page(vector_page), .refresh_count(refresh_count), .first_index_register(),
    .second_index_register(), .instr_done(instr_done), .mcycles_done(mcycles_done), .regs(regs));
  bldec_mem_model u_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic emit(input logic [7:0] b);
    u_mem.cells[pc] = b;
    pc++;
  endtask
  // record the predicted state after one instruction
  task automatic fin(input int t, input int m);
    qt.push_back(t);
    qm.push_back(m);
    qr.push_back({r[7], 8'h00, r[5], r[4], r[3], r[2], r[1], r[0]});
    qf.push_back(fl);
    qv.push_back(vec);
    qrf.push_back(rf);
    qi.push_back(cur_iff);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    md[a] = d;
    qw.push_back({a, d});
  endtask
  // keep a pointer pair out of the code area with an immediate load
  task automatic pr(input int i);
    logic [7:0] v;
    if (r[i] < 8'h10) begin
      v = 8'(rnd()) | 8'h80;
      emit({2'b00, 3'(i), 3'b110});
      emit(v);
      r[i] = v;
      fin(7, 2);
    end
  endtask
  // emit one instruction of the given kind and predict its effect
  task automatic gen(input int kind);
    logic [7:0] n, d, pf;
    logic [2:0] x, y;
    logic [15:0] a;
    int p;
    n = 8'(rnd());
    d = 8'(rnd()) | 8'h80; // negative displacement, index is zero
    pf = rnd() & 1 ? bldec_pkg::PFX_FIRST_INDEX : bldec_pkg::PFX_SECOND_INDEX;
    x = 3'(rnd());
    y = 3'(rnd());
    if (x == 3'h6) x = 3'h7;
    if (y == 3'h6) y = 3'h7;
    a = 16'h1000 + 16'(rnd() % 32'h0000_f000);
    p = n[0] ? 0 : 2;
    if (kind inside {2, 4, 6}) pr(4);
    if (kind inside {8, 10}) pr(p);
    case (kind)
      0: begin emit({2'b01, x, y}); r[x] = r[y]; fin(4, 1); end
      1: begin emit({2'b00, x, 3'b110}); emit(n); r[x] = n; fin(7, 2); end
      2: begin emit({2'b01, x, 3'b110}); r[x] = md[{r[4], r[5]}]; fin(7, 2); end
      3: begin emit(pf); emit({2'b01, x, 3'b110}); emit(d); r[x] = md[{8'hff, d}]; fin(19, 5); end
      4: begin emit({2'b01, 3'b110, x}); wr({r[4], r[5]}, r[x]); fin(7, 2); end
      5: begin emit(pf); emit({2'b01, 3'b110, x}); emit(d); wr({8'hff, d}, r[x]); fin(19, 5); end
      6: begin emit(bldec_pkg::OP_MEM_IMM); emit(n); wr({r[4], r[5]}, n); fin(10, 3); end
      7: begin emit(pf); emit(bldec_pkg::OP_MEM_IMM); emit(d); emit(n); wr({8'hff, d}, n); fin(19, 5); end
      8: begin emit(n[0] ? bldec_pkg::OP_A_FROM_BC : bldec_pkg::OP_A_FROM_DE); r[7] = md[{r[p], r[p+1]}]; fin(7, 2); end
      9: begin emit(bldec_pkg::OP_A_FROM_ABS); emit(a[7:0]); emit(a[15:8]); r[7] = md[a]; fin(13, 4); end
      10: begin emit(n[0] ? bldec_pkg::OP_A_TO_BC : bldec_pkg::OP_A_TO_DE); wr({r[p], r[p+1]}, r[7]); fin(7, 2); end
      11: begin emit(bldec_pkg::OP_A_TO_ABS); emit(a[7:0]); emit(a[15:8]); wr(a, r[7]); fin(13, 4); end
      12: begin
        emit(bldec_pkg::PFX_EXTENDED);
        emit(n[0] ? bldec_pkg::OP_A_FROM_RFSH : bldec_pkg::OP_A_FROM_VEC);
        r[7] = n[0] ? rf : vec;
        fl[bldec_pkg::FLAG_S] = r[7][7];
        fl[bldec_pkg::FLAG_Z] = (r[7] == 8'h00);
        fl[bldec_pkg::FLAG_H] = 1'b0;
        fl[bldec_pkg::FLAG_N] = 1'b0;
        fl[bldec_pkg::FLAG_PV] = cur_iff;
        fin(9, 2);
      end
      default: begin
        emit(bldec_pkg::PFX_EXTENDED);
        emit(n[0] ? bldec_pkg::OP_RFSH_FROM_A : bldec_pkg::OP_VEC_FROM_A);
        if (n[0]) rf = r[7];
        else vec = r[7];
        fin(9, 2);
      end
    endcase
  endtask

  // compare each retired instruction and each write with the model
  always @(negedge ref_clk) begin
    gap = gap + 1;
    if (rst_n && mem_req.wr === 1'b1 && k < qt.size()) begin
      check({mem_req.addr, mem_req.wdata}, qw.size() > 0 ? qw.pop_front() : 'x);
    end
    if (rst_n && instr_done === 1'b1 && k < qt.size()) begin
      check(regs & ~64'h00ff_0000_0000_0000, qr[k]);
      check(flags, qf[k]);
      check({vector_page, refresh_count}, {qv[k], qrf[k]});
      check(mcycles_done, qm[k]);
      if (k > 0) check(gap, qt[k]);
      k++;
      gap = 0;
      if (k < qi.size()) next_iff = qi[k];
    end
  end

  // watchdog: far beyond the longest program at nineteen periods each
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    results();
  end

  initial begin
    for (int i = 0; i < 65536; i++) begin
      md[i] = (i < 4096) ? 8'h00 : 8'(rnd());
      u_mem.cells[i] = md[i];
    end
    r = '{default: 8'h00};
    // every kind once in order, then random kinds
    for (int i = 0; i < 160; i++) begin
      cur_iff = 1'(rnd());
      gen(i < 14 ? i : int'(rnd() % 14));
    end
    next_iff = qi[0];
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 8000 && k < qt.size(); c++) @(posedge ref_clk);
    check(k, qt.size());
    check(qw.size(), 0);
    $display("random load program of %0d instructions finished", qt.size());
    results();
  end
endmodule
`default_nettype wire
